// ==== src/chm_monitor.sv ====
// Monitor end: I2C target, result and event registers, derating, detectors.
`timescale 1ns/1ps
module chm_monitor (
  input wire logic clock,  // System clock
  input wire logic reset_n,  // Synchronous reset
  chm_link_if.dev link,  // I2C and interrupt wires
  input wire logic [1:0] addr_sel,  // Address strap
  input wire logic [chm_pkg::ADC_CH-1:0][chm_pkg::ADC_W-1:0] adc_code,  // Results
  input wire logic signed [7:0] batt_temp,  // Battery temperature, degrees
  input wire logic charging,  // Charge in progress
  input wire logic adapter_present,  // Adapter pin
  input wire logic fault,  // Operating fault pin
  input wire logic [chm_pkg::NDET-1:0] det_low,  // Port below identification level
  output logic [chm_pkg::NDET-1:0] det_pull_en,  // Raise port above detection level
  output logic [chm_pkg::NPATH-1:0] path_drv,  // Path transistor drivers
  output logic chg_en,  // Charger allowed
  output logic [1:0] ichg_scale,  // Charge current scale code
  output logic vtgt_drop  // Lower target by 0.1 V per cell
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 4 + chm_pkg::NDET;
  logic [NPIN-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_p_r;
  logic scl_f, sda_f, scl_rise, scl_fall, i2c_start, i2c_stop, adapt_f, fault_f;
  logic [chm_pkg::NDET-1:0] det_f;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      pin_s3_r <= '1;
      pin_f_r <= '1;
      pin_p_r <= '1;
    end else begin
      pin_s1_r <= {det_low, fault, adapter_present, link.sda, link.scl};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
      pin_p_r <= pin_f_r;
    end
  end
  assign scl_f = pin_f_r[0];
  assign sda_f = pin_f_r[1];
  assign adapt_f = pin_f_r[2];
  assign fault_f = pin_f_r[3];
  assign det_f = pin_f_r[NPIN-1:4];
  assign scl_rise = scl_f && !pin_p_r[0];
  assign scl_fall = !scl_f && pin_p_r[0];
  assign i2c_start = scl_f && pin_p_r[0] && !sda_f && pin_p_r[1];
  assign i2c_stop = scl_f && pin_p_r[0] && sda_f && !pin_p_r[1];

  // ****************************************
  // I2C target
  // ****************************************
  function automatic logic [6:0] tgt_addr(input logic [1:0] sel);
    unique case (sel)
      2'h0: tgt_addr = chm_pkg::TGT_ADDR_0;
      2'h1: tgt_addr = chm_pkg::TGT_ADDR_1;
      2'h2: tgt_addr = chm_pkg::TGT_ADDR_2;
      2'h3: tgt_addr = chm_pkg::TGT_ADDR_3;
    endcase
  endfunction
  chm_pkg::chm_tgt_t st_r;
  logic [1:0] sel_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r, tx_r, ptr_r, rdata;
  logic ack_r, rw_r, wr_pulse;
  // The strap is caught while reset is held, so a later change is ignored.
  always_ff @(posedge clock) begin
    if (!reset_n) sel_r <= addr_sel;
  end
  always_ff @(posedge clock) begin
    if (!reset_n) sh_r <= 8'h00;
    else if (scl_rise) sh_r <= {sh_r[6:0], sda_f};
  end
  assign wr_pulse = scl_fall && st_r == chm_pkg::G_WDAT && bit_r == 4'h7;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r <= chm_pkg::G_IDLE;
      bit_r <= 4'h0;
      ack_r <= 1'b0;
      rw_r <= 1'b0;
      ptr_r <= 8'h00;
      tx_r <= 8'hff;
    end else if (i2c_start) begin
      st_r <= chm_pkg::G_ADDR;
      // The start's own SCL fall wraps the count to zero, so bit 0 starts at zero.
      bit_r <= 4'hf;
      ack_r <= 1'b0;
    end else if (i2c_stop) begin
      st_r <= chm_pkg::G_IDLE;
      ack_r <= 1'b0;
    end else if (scl_fall && st_r != chm_pkg::G_IDLE && st_r != chm_pkg::G_IGN) begin
      if (bit_r == 4'h7) begin
        bit_r <= 4'h8;
        unique case (st_r)
          chm_pkg::G_ADDR: begin
            if (sh_r[7:1] == tgt_addr(sel_r)) begin
              ack_r <= 1'b1;
              rw_r <= sh_r[0];
            end else begin
              st_r <= chm_pkg::G_IGN;
            end
          end
          chm_pkg::G_REG: begin
            ack_r <= 1'b1;
            ptr_r <= sh_r;
          end
          chm_pkg::G_WDAT: ack_r <= 1'b1;
          default: ack_r <= 1'b0;
        endcase
      end else if (bit_r == 4'h8) begin
        ack_r <= 1'b0;
        bit_r <= 4'h0;
        unique case (st_r)
          chm_pkg::G_ADDR: begin
            st_r <= rw_r ? chm_pkg::G_RDAT : chm_pkg::G_REG;
            tx_r <= rdata;
          end
          chm_pkg::G_REG: st_r <= chm_pkg::G_WDAT;
          default: st_r <= chm_pkg::G_IGN;
        endcase
      end else begin
        bit_r <= bit_r + 4'h1;
        if (st_r == chm_pkg::G_RDAT) tx_r <= {tx_r[6:0], 1'b1};
      end
    end
  end
  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe = ack_r || (st_r == chm_pkg::G_RDAT && bit_r < 4'h8 && !tx_r[7]);

  // ****************************************
  // Registers
  // ****************************************
  logic [chm_pkg::NFLAG-1:0] flags_r, imask_r, ev;
  logic [7:0] ntc_cfg_r;
  logic signed [7:0] low_cut_r, high_cut_r, low_rec_r, high_rec_r;
  logic [chm_pkg::NDET-1:0] det_armed_r;
  chm_pkg::chm_tstate_t ts_r;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      imask_r <= '0;
      det_pull_en <= '0;
      path_drv <= '0;
      ntc_cfg_r <= 8'h00;
      low_cut_r <= 8'sh00;
      high_cut_r <= 8'sh2d;
      low_rec_r <= 8'sh05;
      high_rec_r <= 8'sh28;
    end else if (wr_pulse) begin
      unique case (ptr_r)
        chm_pkg::RA_IMASK: imask_r <= sh_r[chm_pkg::NFLAG-1:0];
        chm_pkg::RA_DET: det_pull_en <= sh_r[chm_pkg::NDET-1:0];
        chm_pkg::RA_PATH: path_drv <= sh_r[chm_pkg::NPATH-1:0];
        chm_pkg::RA_NTC_CFG: ntc_cfg_r <= sh_r;
        chm_pkg::RA_LOW_CUT: low_cut_r <= sh_r;
        chm_pkg::RA_HIGH_CUT: high_cut_r <= sh_r;
        chm_pkg::RA_LOW_REC: low_rec_r <= sh_r;
        chm_pkg::RA_HIGH_REC: high_rec_r <= sh_r;
        default: ;
      endcase
    end
  end
  // Results are split into a high nibble byte and a low byte at 2n and 2n+1.
  always_comb begin
    rdata = 8'h00;
    if (ptr_r < chm_pkg::RA_ADC_BASE + 8'(2 * chm_pkg::ADC_CH)) begin
      if (ptr_r[0]) rdata = adc_code[ptr_r[4:1]][7:0];
      else rdata = {4'h0, adc_code[ptr_r[4:1]][11:8]};
    end else begin
      unique case (ptr_r)
        chm_pkg::RA_FLAGS: rdata = 8'(flags_r);
        chm_pkg::RA_IMASK: rdata = 8'(imask_r);
        chm_pkg::RA_DET: rdata = {4'h0, 2'(det_armed_r), 2'(det_pull_en)};
        chm_pkg::RA_PATH: rdata = 8'(path_drv);
        chm_pkg::RA_NTC_CFG: rdata = ntc_cfg_r;
        chm_pkg::RA_LOW_CUT: rdata = low_cut_r;
        chm_pkg::RA_HIGH_CUT: rdata = high_cut_r;
        chm_pkg::RA_LOW_REC: rdata = low_rec_r;
        chm_pkg::RA_HIGH_REC: rdata = high_rec_r;
        chm_pkg::RA_TSTAT: rdata = {chg_en, vtgt_drop, ichg_scale, 1'b0, 3'(ts_r)};
        default: rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Events, detectors and interrupt
  // ****************************************
  logic [chm_pkg::NDET-1:0] det_hit;
  assign det_hit = det_pull_en & det_armed_r & det_f;
  // A detector disarms on its trigger and rearms only while its enable is off.
  always_ff @(posedge clock) begin
    if (!reset_n) det_armed_r <= '1;
    else det_armed_r <= ~det_pull_en | (det_armed_r & ~det_hit);
  end
  always_comb begin
    ev = '0;
    ev[chm_pkg::FL_ADAPT] = !adapt_f && pin_p_r[2];
    ev[chm_pkg::FL_FAULT] = fault_f && !pin_p_r[3];
    ev[chm_pkg::FL_DET0 +: chm_pkg::NDET] = det_hit;
  end
  // Write one to clear; an event in the same cycle keeps its flag set.
  always_ff @(posedge clock) begin
    if (!reset_n) flags_r <= '0;
    else if (wr_pulse && ptr_r == chm_pkg::RA_FLAGS)
      flags_r <= (flags_r & ~sh_r[chm_pkg::NFLAG-1:0]) | ev;
    else flags_r <= flags_r | ev;
  end
  assign link.d_irq_o = 1'b0;
  assign link.d_irq_oe = |(flags_r & imask_r);

  // ****************************************
  // Battery temperature derating
  // ****************************************
  logic signed [8:0] t, lo, hi, m;
  assign t = 9'(batt_temp);
  assign lo = 9'(low_cut_r);
  assign hi = 9'(high_cut_r);
  assign m = ntc_cfg_r[0] ? chm_pkg::MARGIN_FAR : chm_pkg::MARGIN_NEAR;
  always_ff @(posedge clock) begin
    if (!reset_n || !charging) ts_r <= chm_pkg::T_NORMAL;
    else begin
      unique case (ts_r)
        chm_pkg::T_NORMAL:
          if (t <= lo + m) ts_r <= chm_pkg::T_COOL;
          else if (t >= hi - m) ts_r <= chm_pkg::T_WARM;
        chm_pkg::T_COOL:
          if (t <= lo) ts_r <= chm_pkg::T_COLD_OFF;
          else if (t > lo + m) ts_r <= chm_pkg::T_NORMAL;
        chm_pkg::T_COLD_OFF:
          if (t >= lo + chm_pkg::RESUME_MARGIN) ts_r <= chm_pkg::T_COLD_RES;
        chm_pkg::T_COLD_RES:
          if (t <= lo) ts_r <= chm_pkg::T_COLD_OFF;
          else if (t >= 9'(low_rec_r) + m) ts_r <= chm_pkg::T_NORMAL;
        chm_pkg::T_WARM:
          if (t >= hi) ts_r <= chm_pkg::T_HOT_OFF;
          else if (t < hi - m) ts_r <= chm_pkg::T_NORMAL;
        chm_pkg::T_HOT_OFF:
          if (t <= hi - chm_pkg::RESUME_MARGIN) ts_r <= chm_pkg::T_HOT_RES;
        chm_pkg::T_HOT_RES:
          if (t >= hi) ts_r <= chm_pkg::T_HOT_OFF;
          else if (t <= 9'(high_rec_r) - m) ts_r <= chm_pkg::T_NORMAL;
        default: ts_r <= chm_pkg::T_NORMAL;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      chg_en <= 1'b1;
      ichg_scale <= chm_pkg::SCALE_NONE;
      vtgt_drop <= 1'b0;
    end else begin
      chg_en <= ts_r != chm_pkg::T_COLD_OFF && ts_r != chm_pkg::T_HOT_OFF;
      ichg_scale <= (ts_r == chm_pkg::T_COOL || ts_r == chm_pkg::T_COLD_RES)
                    ? ntc_cfg_r[2:1] : chm_pkg::SCALE_NONE;
      vtgt_drop <= (ts_r == chm_pkg::T_COOL && ntc_cfg_r[3]) || ts_r == chm_pkg::T_COLD_RES
                   || (ts_r == chm_pkg::T_WARM && ntc_cfg_r[4])
                   || ts_r == chm_pkg::T_HOT_RES;
    end
  end
endmodule  // chm_monitor

// ==== src/chm_pkg.sv ====
// Shared constants and types for the charger monitor host interface.
package chm_pkg;
  // ****************************************
  // Converter results
  // ****************************************
  localparam int ADC_W = 12;
  localparam int ADC_CH = 9;
  localparam logic [11:0] TDIE_OFFSET = 12'h72f;
  localparam int TDIE_CODES_PER_DEG_X100 = 682;
  localparam int VOLT_STEP_UV = 7500;
  localparam int CURR_STEP_UA = 5000;
  // ****************************************
  // Target addresses and device register map
  // ****************************************
  localparam logic [6:0] TGT_ADDR_0 = 7'h3c;
  localparam logic [6:0] TGT_ADDR_1 = 7'h38;
  localparam logic [6:0] TGT_ADDR_2 = 7'h1c;
  localparam logic [6:0] TGT_ADDR_3 = 7'h18;
  localparam logic [7:0] RA_ADC_BASE = 8'h00;
  localparam logic [7:0] RA_FLAGS = 8'h20;
  localparam logic [7:0] RA_IMASK = 8'h21;
  localparam logic [7:0] RA_DET = 8'h22;
  localparam logic [7:0] RA_PATH = 8'h23;
  localparam logic [7:0] RA_NTC_CFG = 8'h24;
  localparam logic [7:0] RA_LOW_CUT = 8'h25;
  localparam logic [7:0] RA_HIGH_CUT = 8'h26;
  localparam logic [7:0] RA_LOW_REC = 8'h27;
  localparam logic [7:0] RA_HIGH_REC = 8'h28;
  localparam logic [7:0] RA_TSTAT = 8'h29;
  localparam int NFLAG = 4;
  localparam int FL_ADAPT = 0;
  localparam int FL_DET0 = 1;
  localparam int FL_FAULT = 3;
  localparam int NDET = 2;
  localparam int NPATH = 3;
  // ****************************************
  // Battery temperature derating, target and controller state types
  // ****************************************
  localparam logic signed [8:0] MARGIN_NEAR = 9'sh005;
  localparam logic signed [8:0] MARGIN_FAR = 9'sh00a;
  localparam logic signed [8:0] RESUME_MARGIN = 9'sh005;
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_HALF = 2'h1;
  localparam logic [1:0] SCALE_QUARTER = 2'h2;
  typedef enum logic [2:0] {T_NORMAL, T_COOL, T_COLD_OFF, T_COLD_RES,
                            T_WARM, T_HOT_OFF, T_HOT_RES} chm_tstate_t;
  typedef enum logic [2:0] {G_IDLE, G_ADDR, G_REG, G_WDAT, G_RDAT, G_IGN} chm_tgt_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP} chm_hst_t;
  // ****************************************
  // Controller timing and register map
  // ****************************************
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int I2C_HZ = 100_000;
  localparam int QUARTER_CYC = SYS_CLK_HZ / (4 * I2C_HZ);
  localparam logic [7:0] HA_CTRL = 8'h00;
  localparam logic [7:0] HA_REGADDR = 8'h04;
  localparam logic [7:0] HA_WDATA = 8'h08;
  localparam logic [7:0] HA_STATUS = 8'h0c;
  localparam int CT_GO = 0;
  localparam int CT_READ = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_NACK = 2;
  localparam int ST_IRQ = 3;
endpackage

// ==== src/chm_link_if.sv ====
// Open-drain I2C and interrupt wires joining the controller and the monitor.
`timescale 1ns/1ps
interface chm_link_if;
  logic h_scl_o, h_scl_oe, h_sda_o, h_sda_oe;
  logic d_sda_o, d_sda_oe, d_irq_o, d_irq_oe;
  logic scl, sda, irq_n;
  // Pulled-up wires: low whenever any enabled driver drives a zero.
  assign scl = !(h_scl_oe && !h_scl_o);
  assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));
  assign irq_n = !(d_irq_oe && !d_irq_o);
  modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, input scl, sda, irq_n);
  modport dev (output d_sda_o, d_sda_oe, d_irq_o, d_irq_oe, input scl, sda);
endinterface

// ==== src/chm_host.sv ====
// Controller end: APB registers driving single-register I2C transactions.
`timescale 1ns/1ps
module chm_host #(
  parameter int QUARTER = chm_pkg::QUARTER_CYC  // Cycles per quarter bit
) (
  input wire logic clock,  // System clock
  input wire logic reset_n,  // Synchronous reset
  chm_link_if.host link,  // I2C and interrupt wires
  input wire logic psel,  // APB select
  input wire logic penable,  // APB enable
  input wire logic pwrite,  // APB write
  input wire logic [7:0] paddr,  // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,  // APB read data
  output logic pready,  // APB ready
  output logic pslverr  // APB error
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] s1_r, s2_r, s3_r, f_r;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      f_r <= '1;
    end else begin
      s1_r <= {link.irq_n, link.sda};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
    end
  end

  // ****************************************
  // APB registers
  // ****************************************
  logic acc, go, rd_r, busy, done_r, nack_r, fin, fin_nack;
  logic [7:0] ra_r, wd_r, rx_r;
  assign acc = psel && penable;
  assign pready = 1'b1;
  assign go = acc && pwrite && paddr == chm_pkg::HA_CTRL && pwdata[chm_pkg::CT_GO] && !busy;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rd_r <= 1'b0;
      ra_r <= 8'h00;
      wd_r <= 8'h00;
    end else if (acc && pwrite && !busy) begin
      if (paddr == chm_pkg::HA_CTRL) rd_r <= pwdata[chm_pkg::CT_READ];
      if (paddr == chm_pkg::HA_REGADDR) ra_r <= pwdata[7:0];
      if (paddr == chm_pkg::HA_WDATA) wd_r <= pwdata[7:0];
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (go) begin
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else if (fin) begin
      done_r <= 1'b1;
      nack_r <= fin_nack;
    end
  end
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (acc) begin
      unique case (paddr)
        chm_pkg::HA_CTRL: prdata = {30'h0, rd_r, 1'b0};
        chm_pkg::HA_REGADDR: prdata = {24'h0, ra_r};
        chm_pkg::HA_WDATA: prdata = {24'h0, wd_r};
        chm_pkg::HA_STATUS: prdata = {16'h0, rx_r, 4'h0, !f_r[1], nack_r, done_r, busy};
        default: pslverr = 1'b1;
      endcase
    end
  end

  // ****************************************
  // I2C controller
  // ****************************************
  chm_pkg::chm_hst_t hs_r;
  logic [$clog2(QUARTER)-1:0] qc_r;
  logic [1:0] q_r, byte_r;
  logic [3:0] bit_r;
  logic [7:0] tx_r;
  logic tick, scl_low_r, sda_low_r, rx_byte, last;
  assign busy = hs_r != chm_pkg::H_IDLE;
  assign tick = qc_r == ($clog2(QUARTER))'(QUARTER - 1);
  assign rx_byte = rd_r && byte_r == 2'h3;
  assign last = rd_r ? byte_r == 2'h3 : byte_r == 2'h2;
  always_ff @(posedge clock) begin
    if (!reset_n || !busy || tick) qc_r <= '0;
    else qc_r <= qc_r + 1'b1;
  end
  // Byte order: write address, register, then data or restart and read address.
  function automatic logic [7:0] host_byte(input logic [1:0] i);
    unique case (i)
      2'h0: host_byte = {chm_pkg::TGT_ADDR_0, 1'b0};
      2'h1: host_byte = ra_r;
      2'h2: host_byte = rd_r ? {chm_pkg::TGT_ADDR_0, 1'b1} : wd_r;
      2'h3: host_byte = 8'hff;
    endcase
  endfunction
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hs_r <= chm_pkg::H_IDLE;
      q_r <= 2'h0;
      byte_r <= 2'h0;
      bit_r <= 4'h0;
      tx_r <= 8'hff;
      rx_r <= 8'h00;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      fin <= 1'b0;
      fin_nack <= 1'b0;
    end else begin
      fin <= 1'b0;
      if (go) begin
        hs_r <= chm_pkg::H_START;
        q_r <= 2'h0;
        byte_r <= 2'h0;
        fin_nack <= 1'b0;
      end else if (busy && tick) begin
        q_r <= q_r + 2'h1;
        unique case (hs_r)
          chm_pkg::H_START: begin
            unique case (q_r)
              2'h0: sda_low_r <= 1'b0;
              2'h1: scl_low_r <= 1'b0;
              2'h2: sda_low_r <= 1'b1;
              2'h3: begin
                scl_low_r <= 1'b1;
                hs_r <= chm_pkg::H_BIT;
                bit_r <= 4'h0;
                tx_r <= host_byte(byte_r);
              end
            endcase
          end
          chm_pkg::H_BIT: begin
            unique case (q_r)
              2'h0: sda_low_r <= bit_r < 4'h8 ? !tx_r[7] : (rx_byte ? 1'b0 : 1'b0);
              2'h1: scl_low_r <= 1'b0;
              2'h2: begin
                if (bit_r < 4'h8) rx_r <= rx_byte ? {rx_r[6:0], f_r[0]} : rx_r;
                else if (!rx_byte && f_r[0]) fin_nack <= 1'b1;
              end
              2'h3: begin
                scl_low_r <= 1'b1;
                tx_r <= {tx_r[6:0], 1'b1};
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h8) begin
                  byte_r <= byte_r + 2'h1;
                  bit_r <= 4'h0;
                  tx_r <= host_byte(byte_r + 2'h1);
                  if (last || fin_nack || (!rx_byte && f_r[0])) hs_r <= chm_pkg::H_STOP;
                  else if (rd_r && byte_r == 2'h1) hs_r <= chm_pkg::H_START;
                end
              end
            endcase
          end
          chm_pkg::H_STOP: begin
            unique case (q_r)
              2'h0: sda_low_r <= 1'b1;
              2'h1: scl_low_r <= 1'b0;
              2'h2: sda_low_r <= 1'b0;
              2'h3: begin
                hs_r <= chm_pkg::H_IDLE;
                fin <= 1'b1;
              end
            endcase
          end
          default: hs_r <= chm_pkg::H_IDLE;
        endcase
      end
    end
  end
  assign link.h_scl_o = 1'b0;
  assign link.h_scl_oe = scl_low_r;
  assign link.h_sda_o = 1'b0;
  assign link.h_sda_oe = sda_low_r;
endmodule  // chm_host

// ==== test/chm_sva.sv ====
// Concurrent checks on the wires between the controller and the monitor.
`timescale 1ns/1ps
module chm_sva #(
  parameter int QUARTER = 12  // Cycles per quarter bit
) (
  input wire logic clock,  // System clock
  input wire logic reset_n,  // Synchronous reset
  input wire logic h_scl_oe,  // Host pulls SCL
  input wire logic d_sda_oe,  // Monitor pulls SDA
  input wire logic d_irq_oe,  // Monitor pulls IRQ
  input wire logic scl,  // Resolved SCL
  input wire logic sda,  // Resolved SDA
  input wire logic irq_n  // Resolved interrupt
);
  logic [15:0] sda_cnt_r;
  logic [15:0] scl_cnt_r;
  // A monitor stuck on SDA would hang the bus, so its hold is counted.
  always_ff @(posedge clock) begin
    sda_cnt_r <= (!reset_n || !d_sda_oe) ? 16'h0000 : sda_cnt_r + 16'h0001;
  end
  always_ff @(posedge clock) begin
    scl_cnt_r <= (!reset_n || !h_scl_oe) ? 16'h0000 : scl_cnt_r + 16'h0001;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ****************************************
  // Assertions
  // ****************************************
  reset_quiet_a: assert property ($rose(reset_n) |-> !d_sda_oe && !d_irq_oe)
    else $error("monitor pulls a wire after reset");
  sda_edge_a: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("monitor moved SDA while SCL high");
  start_quiet_a: assert property ($fell(sda) && scl |-> !d_sda_oe)
    else $error("monitor pulls SDA at a start");
  stop_quiet_a: assert property ($rose(sda) && scl |-> !$past(d_sda_oe))
    else $error("monitor pulls SDA at a stop");
  sda_hold_a: assert property (sda_cnt_r < 16'(40 * QUARTER))
    else $error("monitor holds SDA too long");
  irq_release_a: assert property ($fell(d_irq_oe) |-> !scl)
    else $error("interrupt released outside a register write");
  scl_low_max_a: assert property (scl_cnt_r < 16'(4 * QUARTER))
    else $error("SCL low too long");
  scl_low_min_a: assert property ($rose(h_scl_oe) |-> h_scl_oe [*8])
    else $error("SCL low too short");
  cover property ($rose(d_irq_oe));
  cover property ($rose(d_sda_oe));
  cover property ($fell(sda) && scl);
endmodule  // chm_sva

// ==== test/tb_charger_monitor_host_interface.sv ====
// Self-checking bench joining controller and monitor over the shared link.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_charger_monitor_host_interface;
  localparam int QUARTER = 12;
  // Rows of {temperature, mask, expected {chg_en, scale, drop}}.
  localparam logic [15:0] DER [9] = '{16'h19f8, 16'h05fd, 16'h0080, 16'h05ec, 16'h19f8,
                                       16'h28f9, 16'h2d80, 16'h2899, 16'h19f8};
  logic clock, reset_n, psel, penable, pwrite, pslverr, pready, chk;
  logic charging, adapter_present, fault, chg_en, vtgt_drop;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_r;
  logic [1:0] addr_sel, det_low, det_pull_en, ichg_scale;
  logic [2:0] path_drv, pv;
  logic [chm_pkg::ADC_CH-1:0][chm_pkg::ADC_W-1:0] adc_code;
  logic signed [7:0] batt_temp;
  logic [65:0] mv;
  logic [65:0] exp_q[$];
  int mismatches, comparisons, seed;
  chm_link_if chm_link_if_i ();
  chm_monitor chm_monitor_i (.clock(clock), .reset_n(reset_n), .link(chm_link_if_i),
    .addr_sel(addr_sel), .adc_code(adc_code), .batt_temp(batt_temp), .charging(charging),
    .adapter_present(adapter_present), .fault(fault), .det_low(det_low),
    .det_pull_en(det_pull_en), .path_drv(path_drv), .chg_en(chg_en),
    .ichg_scale(ichg_scale), .vtgt_drop(vtgt_drop));
  chm_host #(.QUARTER(QUARTER)) chm_host_i (.clock(clock), .reset_n(reset_n),
    .link(chm_link_if_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  chm_sva #(.QUARTER(QUARTER)) chm_sva_i (.clock(clock), .reset_n(reset_n),
    .h_scl_oe(chm_link_if_i.h_scl_oe), .d_sda_oe(chm_link_if_i.d_sda_oe),
    .d_irq_oe(chm_link_if_i.d_irq_oe), .scl(chm_link_if_i.scl), .sda(chm_link_if_i.sda),
    .irq_n(chm_link_if_i.irq_n));
  // ****************************************
  // Bus tasks and result watcher
  // ****************************************
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic c, input logic [65:0] m);
    if (c) exp_q.push_back(m);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd_r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk <= 1'b0;
  endtask
  // One whole single-register transaction; the final status read is checked.
  task automatic xfer(input logic rd, input logic [7:0] ra, input logic [7:0] d, input logic nk);
    apb(1'b1, chm_pkg::HA_REGADDR, {24'h0, ra}, 1'b0, 66'h0);
    apb(1'b1, chm_pkg::HA_WDATA, {24'h0, d}, 1'b0, 66'h0);
    apb(1'b1, chm_pkg::HA_CTRL, {30'h0, rd, 1'b1}, 1'b0, 66'h0);
    do apb(1'b0, chm_pkg::HA_STATUS, 32'h0, 1'b0, 66'h0); while (rd_r[1:0] !== 2'b10);
    apb(1'b0, chm_pkg::HA_STATUS, 32'h0, 1'b1,
        {(rd && !nk) ? 33'h0ff07 : 33'h7, 17'h0, d, 5'h0, nk, 2'b10});
  endtask
  always @(posedge clock) begin
    if (psel && penable && pready && chk) begin
      mv = exp_q.pop_front();
      `CHK("apb", mv[32:0] & mv[65:33], {pslverr, prdata} & mv[65:33])
    end
  end
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #400000;
    mismatches++;
    complete_run;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 31;
    {psel, penable, pwrite, chk, fault, reset_n} = 6'h0;
    {paddr, pwdata, addr_sel, det_low} = 44'h0;
    {charging, adapter_present} = 2'b11;
    batt_temp = 8'sd25;
    for (int i = 0; i < chm_pkg::ADC_CH; i++) adc_code[i] = 12'($random(seed));
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b0, chm_pkg::HA_STATUS, 32'h0, 1'b1, {33'hf, 33'h0});
    apb(1'b0, 8'h10, 32'h0, 1'b1, {2{33'h100000000}});
    for (int n = 0; n < chm_pkg::ADC_CH; n++) xfer(1'b1, 8'(2 * n + 1), adc_code[n][7:0], 1'b0);
    xfer(1'b1, 8'h04, {4'h0, adc_code[2][11:8]}, 1'b0);
    pv = 3'($random(seed));
    xfer(1'b0, chm_pkg::RA_PATH, {5'h0, pv}, 1'b0);
    `CHK("path", pv, path_drv)
    xfer(1'b0, chm_pkg::RA_IMASK, 8'h08, 1'b0);
    fault <= 1'b1;
    repeat (10) @(posedge clock);
    fault <= 1'b0;
    adapter_present <= 1'b0;
    repeat (10) @(posedge clock);
    apb(1'b0, chm_pkg::HA_STATUS, 32'h0, 1'b1, {33'h8, 33'h8});
    xfer(1'b1, chm_pkg::RA_FLAGS, 8'h09, 1'b0);
    xfer(1'b0, chm_pkg::RA_FLAGS, 8'h08, 1'b0);
    apb(1'b0, chm_pkg::HA_STATUS, 32'h0, 1'b1, {33'h8, 33'h0});
    xfer(1'b0, chm_pkg::RA_DET, 8'h01, 1'b0);
    `CHK("det", 2'b01, det_pull_en)
    det_low <= 2'b01;
    repeat (10) @(posedge clock);
    det_low <= 2'b00;
    xfer(1'b1, chm_pkg::RA_DET, 8'h09, 1'b0);
    xfer(1'b0, chm_pkg::RA_DET, 8'h00, 1'b0);
    xfer(1'b0, chm_pkg::RA_DET, 8'h01, 1'b0);
    xfer(1'b1, chm_pkg::RA_DET, 8'h0d, 1'b0);
    xfer(1'b0, chm_pkg::RA_NTC_CFG, 8'h1c, 1'b0);
    for (int k = 0; k < 9; k++) begin
      batt_temp <= DER[k][15:8];
      repeat (4) @(posedge clock);
      `CHK("derate", DER[k][3:0] & DER[k][7:4], {chg_en, ichg_scale, vtgt_drop} & DER[k][7:4])
    end
    xfer(1'b0, chm_pkg::RA_NTC_CFG, 8'h03, 1'b0);
    batt_temp <= 8'sd10;
    repeat (4) @(posedge clock);
    `CHK("margin", 4'ha, {chg_en, ichg_scale, vtgt_drop})
    xfer(1'b1, chm_pkg::RA_TSTAT, 8'h91, 1'b0);
    charging <= 1'b0;
    batt_temp <= 8'sd0;
    repeat (4) @(posedge clock);
    `CHK("idle", 4'h8, {chg_en, ichg_scale, vtgt_drop})
    reset_n <= 1'b0;
    addr_sel <= 2'b01;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK("path reset", 3'h0, path_drv)
    xfer(1'b1, chm_pkg::RA_PATH, 8'h00, 1'b1);
    complete_run;
  end
endmodule  // tb_charger_monitor_host_interface
